// [design/gms_edge_counter.sv]
// One detector channel counter with selectable count edge
`timescale 1ns/10ps
module gms_edge_counter #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic resetn_in,
  // Detector pulse
  input  wire logic det_in,
  // Sequencer side
  gms_cnt_if.cnt    cif
);
  logic det_q;
  logic hit;

  if (CNT_W < 2) begin : g_chk
    $error("CNT_W too small");
  end

  // Previous detector level for edge detection
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) det_q <= 1'b0;
    else det_q <= det_in;
  end

  assign hit = cif.neg_edge ? (det_q & ~det_in) : (~det_q & det_in); // R18

  // Clear keeps an edge of the same cycle so none is lost
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cif.count <= '0;
    end else if (cif.clear) begin
      cif.count <= (cif.enable && hit) ? CNT_W'(1) : '0; // R23
    end else if (cif.enable && hit) begin
      cif.count <= cif.count + CNT_W'(1); // R18
    end
  end

  property p_clear;
    @(posedge clk_in) disable iff (!resetn_in)
    cif.clear && !hit |=> cif.count == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("counter not cleared"); // R23

  property p_edge;
    @(posedge clk_in) disable iff (!resetn_in)
    !cif.clear && cif.enable && hit |=> cif.count == $past(cif.count) + CNT_W'(1);
  endproperty
  a_edge: assert property (p_edge) else $error("selected edge not counted"); // R18
endmodule // gms_edge_counter

// [design/gms_top.sv]
// Gated two-channel multiscaler sequencer with APB registers
//
// How it works
// R1: None start records at software start.
// R2: Edge start arms, waits for edge.
// R3: Multiscaler stores each interval at next address.
// R4: Point interval down to 250 ns; the code's shortest interval is 63 cycles, 252 ns.
// R5: Last 50 ns of interval are readout; the code reads out in the last 13 cycles, 52 ns.
// R6: One trigger starts whole curve or sweep.
// R7: Per-point stepping needs trigger per interval.
// R8: Accumulate restarts on trigger, adds memory.
// R9: Repeat at interval, else immediately after.
// R10: Event mode compares result against threshold.
// R11: Over threshold stores both channels, time.
// R12: Event mode stops at points stored events.
// R13: Event counting window 50 ns short; the code shortens it by 13 cycles, 52 ns.
// R14: Rates repeat restarts immediately or edge.
// R15: Flag repeat time expired before finish.
// R16: In-progress status set at start.
// R17: Triggered status set when trigger satisfied.
// R18: Count edge selectable per channel.
// R19: Own start condition and trigger input.
// R20: Collect inactive during readout, active counting.
// R21: Points per curve 2 to 65536.
// R22: Write pointer reset at curve start.
// R23: Counters cleared at each interval start.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
`include "gms_params.svh"
module gms_top #(
  parameter int MEM_DEPTH = 65536,
  parameter int CNT_W     = 32
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // APB slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Detector and control pins
  input  wire logic [1:0]  det_in,
  input  wire logic        trig_in,
  input  wire logic        disable_arm_n_in,
  input  wire logic        disable_collect_n_in,
  output logic             armed_n_out,
  output logic             measure_n_out,
  output logic             collect_n_out
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam logic [31:0] RO_CYC  = 32'(`GMS_READOUT_CYC);
  localparam logic [31:0] MIN_TPP = 32'(`GMS_MIN_TPP_CYC);

  if (MEM_DEPTH < 2 || CNT_W < 2 || CNT_W > 32) begin : g_chk
    $error("unsupported MEM_DEPTH or CNT_W");
  end

  gms_pkg::gms_state_t st;
  gms_pkg::gms_mode_t  mode;
  gms_pkg::gms_tcond_t tcond;
  logic             start_p, stop_p, acc_en, rep_en, step_en;
  logic [1:0]       neg_sel;
  logic [31:0]      tpp, rep_cyc, thresh, rep_cnt, tcnt, ts;
  logic [16:0]      points, point, evt_cnt;
  logic [15:0]      sweeps, sweep;
  logic [AW-1:0]    base, rd_addr, wptr;
  logic             in_prog, trig_st, rep_exp;
  logic [CNT_W-1:0] mem_a [MEM_DEPTH];
  logic [CNT_W-1:0] mem_b [MEM_DEPTH];
  logic [31:0]      mem_t [MEM_DEPTH];
  logic             cnt_clr;
  logic [CNT_W-1:0] cnt_a, cnt_b;
  logic             trig_q, trig_hit, edge_mode, per_pt, pt_go, over, store, end_pt;
  logic             last_pt, more_sweep, done;
  logic [31:0]      tpp_eff, coll_len;
  logic [16:0]      evt_next;
  logic             apb_setup, apb_wr, hit_ok, rep_hit, busy;
  logic [31:0]      rd_val;
  logic [16:0]      pts_wr;

  // Channel counters, one per detector input
  gms_cnt_if #(.CNT_W(CNT_W)) cif [2] ();
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign cif[g].clear    = cnt_clr;
    assign cif[g].enable   = (st == gms_pkg::GMS_CNT);
    assign cif[g].neg_edge = neg_sel[g]; // R18
    gms_edge_counter #(.CNT_W(CNT_W)) u_cnt (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .det_in    (det_in[g]),
      .cif       (cif[g])
    );
  end
  assign cnt_a = cif[0].count;
  assign cnt_b = cif[1].count;

  // Interval timing; short settings are stretched to the shortest point
  assign tpp_eff  = (tpp < MIN_TPP) ? MIN_TPP : tpp; // R4
  assign coll_len = tpp_eff - RO_CYC; // R5 R13

  // Trigger edge detection on this module's own input
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) trig_q <= 1'b0;
    else trig_q <= trig_in;
  end
  assign trig_hit  = (tcond == gms_pkg::GMS_TRISE && trig_in && !trig_q) ||
                     (tcond == gms_pkg::GMS_TFALL && !trig_in && trig_q); // R19
  assign edge_mode = (tcond != gms_pkg::GMS_TNONE);
  assign per_pt    = edge_mode && step_en && (mode == gms_pkg::GMS_MSCAL); // R7
  assign pt_go     = disable_collect_n_in && (!per_pt || trig_hit);

  // Store decision at the first readout cycle
  assign over     = (cnt_a > thresh[CNT_W-1:0]) || (cnt_b > thresh[CNT_W-1:0]); // R10 R11
  assign store    = (st == gms_pkg::GMS_READ) && (tcnt == coll_len) &&
                    (mode != gms_pkg::GMS_EVENT || over);
  assign end_pt   = (st == gms_pkg::GMS_READ) && (tcnt == tpp_eff - 32'd1);
  assign evt_next = evt_cnt + 17'(store);
  assign last_pt  = (point == points - 17'd1);
  assign more_sweep = acc_en && (sweep != sweeps - 16'd1) && (mode == gms_pkg::GMS_MSCAL);
  assign done = (mode == gms_pkg::GMS_RATES) ||
                (mode == gms_pkg::GMS_MSCAL && last_pt && !more_sweep) ||
                (mode == gms_pkg::GMS_EVENT && evt_next >= points); // R12

  // Result memory; accumulation adds to what is stored
  always_ff @(posedge clk_in) begin
    if (store) begin
      if (acc_en && mode == gms_pkg::GMS_MSCAL) begin
        mem_a[wptr] <= mem_a[wptr] + cnt_a; // R8
        mem_b[wptr] <= mem_b[wptr] + cnt_b; // R8
      end else begin
        mem_a[wptr] <= cnt_a; // R3
        mem_b[wptr] <= cnt_b; // R11
      end
      mem_t[wptr] <= ts; // R11
    end
  end

  // Main sequencer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st            <= gms_pkg::GMS_IDLE;
      tcnt          <= 32'h0000_0000;
      point         <= 17'h0_0000;
      sweep         <= 16'h0000;
      evt_cnt       <= 17'h0_0000;
      wptr          <= '0;
      cnt_clr       <= 1'b0;
      in_prog       <= 1'b0;
      trig_st       <= 1'b0;
      armed_n_out   <= 1'b1;
      measure_n_out <= 1'b1;
      collect_n_out <= 1'b1;
    end else begin
      cnt_clr <= 1'b0;
      if (stop_p) begin
        st            <= gms_pkg::GMS_IDLE;
        in_prog       <= 1'b0;
        armed_n_out   <= 1'b1;
        measure_n_out <= 1'b1;
        collect_n_out <= 1'b1;
      end else begin
        case (st)
          gms_pkg::GMS_IDLE: begin
            if (start_p) begin
              st          <= gms_pkg::GMS_ARM;
              point       <= 17'h0_0000;
              sweep       <= 16'h0000;
              evt_cnt     <= 17'h0_0000;
              wptr        <= base; // R22
              in_prog     <= 1'b1; // R16
              trig_st     <= 1'b0;
              armed_n_out <= 1'b0;
            end
          end
          gms_pkg::GMS_ARM: begin
            // Edge conditions only arm; none starts at once
            if (disable_arm_n_in && (!edge_mode || trig_hit)) begin // R1 R2 R6 R14
              st            <= gms_pkg::GMS_CNT;
              tcnt          <= 32'h0000_0000;
              cnt_clr       <= 1'b1; // R23
              trig_st       <= 1'b1; // R17
              measure_n_out <= 1'b0;
              collect_n_out <= 1'b0; // R20
            end
          end
          gms_pkg::GMS_CNT: begin
            tcnt <= tcnt + 32'd1;
            if (tcnt == coll_len - 32'd1) begin
              st            <= gms_pkg::GMS_READ;
              collect_n_out <= 1'b1; // R5 R20
            end
          end
          gms_pkg::GMS_READ: begin
            tcnt <= tcnt + 32'd1;
            if (store && mode != gms_pkg::GMS_RATES) wptr <= wptr + AW'(1); // R3
            if (store && mode == gms_pkg::GMS_EVENT) evt_cnt <= evt_next;
            if (end_pt) begin
              if (done) begin
                measure_n_out <= 1'b1;
                if (rep_en) begin
                  st <= gms_pkg::GMS_WREP; // R9
                end else begin
                  st          <= gms_pkg::GMS_IDLE;
                  in_prog     <= 1'b0;
                  armed_n_out <= 1'b1;
                end
              end else if (mode == gms_pkg::GMS_MSCAL && last_pt) begin
                st    <= gms_pkg::GMS_WSWP;
                sweep <= sweep + 16'd1;
                point <= 17'h0_0000;
                wptr  <= base; // R22
              end else begin
                if (mode == gms_pkg::GMS_MSCAL) point <= point + 17'd1;
                if (pt_go) begin
                  st            <= gms_pkg::GMS_CNT; // R6
                  tcnt          <= 32'h0000_0000;
                  cnt_clr       <= 1'b1; // R23
                  collect_n_out <= 1'b0;
                end else begin
                  st <= gms_pkg::GMS_WPT;
                end
              end
            end
          end
          gms_pkg::GMS_WPT: begin
            if (pt_go) begin // R7
              st            <= gms_pkg::GMS_CNT;
              tcnt          <= 32'h0000_0000;
              cnt_clr       <= 1'b1;
              collect_n_out <= 1'b0;
            end
          end
          gms_pkg::GMS_WSWP: begin
            if (!edge_mode || trig_hit) begin // R8
              st            <= gms_pkg::GMS_CNT;
              tcnt          <= 32'h0000_0000;
              cnt_clr       <= 1'b1;
              collect_n_out <= 1'b0;
            end
          end
          gms_pkg::GMS_WREP: begin
            // Waits out the repeat interval, zero when already over
            if (rep_cnt >= rep_cyc) begin // R9 R14
              st      <= gms_pkg::GMS_ARM;
              point   <= 17'h0_0000;
              sweep   <= 16'h0000;
              evt_cnt <= 17'h0_0000;
              wptr    <= base; // R22
            end
          end
          default: st <= gms_pkg::GMS_IDLE;
        endcase
      end
    end
  end

  // Time since measurement start, used as event time stamp
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) ts <= 32'h0000_0000;
    else if (st == gms_pkg::GMS_ARM) ts <= 32'h0000_0000;
    else ts <= ts + 32'd1;
  end

  // Repeat timer runs from each measurement start; saturates
  assign busy    = (st != gms_pkg::GMS_IDLE) && (st != gms_pkg::GMS_WREP);
  assign rep_hit = rep_en && (rep_cnt == rep_cyc) && (rep_cyc != 32'h0000_0000);
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) rep_cnt <= 32'h0000_0000;
    else if ((st == gms_pkg::GMS_IDLE && start_p) || (st == gms_pkg::GMS_WREP && rep_cnt >= rep_cyc))
      rep_cnt <= 32'h0000_0000;
    else if (rep_cnt != 32'hFFFF_FFFF) rep_cnt <= rep_cnt + 32'd1;
  end

  // Sticky repeat-expired flag; a new expiry wins over a clear
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) rep_exp <= 1'b0;
    else if (rep_hit && busy) rep_exp <= 1'b1; // R15
    else if (apb_wr && paddr_in == `GMS_OFS_STATUS && pwdata_in[`GMS_ST_REPEXP]) rep_exp <= 1'b0;
  end

  // APB handshake: one wait state so read data comes from a flop
  assign apb_setup = psel_in && penable_in && !pready_out;
  assign apb_wr    = psel_in && penable_in && pready_out && pwrite_in;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup && !hit_ok;
      if (apb_setup && !pwrite_in) prdata_out <= rd_val;
    end
  end

  // Read decode
  always_comb begin
    hit_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr_in)
      `GMS_OFS_CTRL:   rd_val = {21'h0, neg_sel, step_en, rep_en, acc_en, tcond, mode, 2'h0};
      `GMS_OFS_TPP:    rd_val = tpp;
      `GMS_OFS_POINTS: rd_val = {15'h0, points};
      `GMS_OFS_SWEEPS: rd_val = {16'h0, sweeps};
      `GMS_OFS_REPEAT: rd_val = rep_cyc;
      `GMS_OFS_THRESH: rd_val = thresh;
      `GMS_OFS_BASE:   rd_val = 32'(base);
      `GMS_OFS_STATUS: rd_val = {27'h0, ~collect_n_out, ~armed_n_out, rep_exp, trig_st, in_prog};
      `GMS_OFS_RDADDR: rd_val = 32'(rd_addr);
      `GMS_OFS_RDCH0:  rd_val = 32'(mem_a[rd_addr]);
      `GMS_OFS_RDCH1:  rd_val = 32'(mem_b[rd_addr]);
      `GMS_OFS_RDTIME: rd_val = mem_t[rd_addr];
      `GMS_OFS_EVTCNT: rd_val = {15'h0, evt_cnt};
      default:         hit_ok = 1'b0;
    endcase
  end

  // Points clamped into the supported range
  assign pts_wr = (pwdata_in[31:0] < 32'(`GMS_POINTS_MIN)) ? `GMS_POINTS_MIN :
                  (pwdata_in[31:0] > 32'(`GMS_POINTS_MAX)) ? `GMS_POINTS_MAX : pwdata_in[16:0];

  // Configuration registers and start/stop pulses
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_p <= 1'b0;
      stop_p  <= 1'b0;
      mode    <= gms_pkg::GMS_RATES;
      tcond   <= gms_pkg::GMS_TNONE;
      acc_en  <= 1'b0;
      rep_en  <= 1'b0;
      step_en <= 1'b0;
      neg_sel <= 2'h0;
      tpp     <= `GMS_RST_TPP;
      points  <= `GMS_RST_POINTS;
      sweeps  <= `GMS_RST_SWEEPS;
      rep_cyc <= `GMS_RST_REPEAT;
      thresh  <= `GMS_RST_THRESH;
      base    <= '0;
      rd_addr <= '0;
    end else begin
      start_p <= apb_wr && paddr_in == `GMS_OFS_CTRL && pwdata_in[`GMS_CTRL_START];
      stop_p  <= apb_wr && paddr_in == `GMS_OFS_CTRL && pwdata_in[`GMS_CTRL_STOP];
      if (apb_wr) begin
        case (paddr_in)
          `GMS_OFS_CTRL: begin
            mode    <= gms_pkg::gms_mode_t'(pwdata_in[`GMS_CTRL_MODE]);
            tcond   <= gms_pkg::gms_tcond_t'(pwdata_in[`GMS_CTRL_TCOND]); // R19
            acc_en  <= pwdata_in[`GMS_CTRL_ACC];
            rep_en  <= pwdata_in[`GMS_CTRL_REP];
            step_en <= pwdata_in[`GMS_CTRL_STEP];
            neg_sel <= pwdata_in[`GMS_CTRL_NEG]; // R18
          end
          `GMS_OFS_TPP:    tpp     <= pwdata_in;
          `GMS_OFS_POINTS: points  <= pts_wr; // R21
          `GMS_OFS_SWEEPS: sweeps  <= (pwdata_in[15:0] == 16'h0000) ? 16'h0001 : pwdata_in[15:0];
          `GMS_OFS_REPEAT: rep_cyc <= pwdata_in;
          `GMS_OFS_THRESH: thresh  <= pwdata_in;
          `GMS_OFS_BASE:   base    <= pwdata_in[AW-1:0];
          `GMS_OFS_RDADDR: rd_addr <= pwdata_in[AW-1:0];
          default: ;
        endcase
      end
    end
  end

  property p_none_start;
    @(posedge clk_in) disable iff (!resetn_in)
    (st == gms_pkg::GMS_IDLE && start_p && !stop_p && tcond == gms_pkg::GMS_TNONE)
      ##1 (disable_arm_n_in && !stop_p) |=> !collect_n_out && !measure_n_out;
  endproperty
  a_none_start: assert property (p_none_start) else $error("none start did not record"); // R1

  property p_armed_wait;
    @(posedge clk_in) disable iff (!resetn_in)
    st == gms_pkg::GMS_ARM && edge_mode && !trig_hit && !stop_p |=> st == gms_pkg::GMS_ARM && collect_n_out;
  endproperty
  a_armed_wait: assert property (p_armed_wait) else $error("recording began without edge"); // R2

  property p_readout;
    @(posedge clk_in) disable iff (!resetn_in)
    st == gms_pkg::GMS_CNT && tcnt == coll_len - 32'd1 && !stop_p |=> st == gms_pkg::GMS_READ && collect_n_out;
  endproperty
  a_readout: assert property (p_readout) else $error("readout phase missing"); // R5

  property p_collect_low;
    @(posedge clk_in) disable iff (!resetn_in)
    st == gms_pkg::GMS_READ |-> collect_n_out;
  endproperty
  a_collect_low: assert property (p_collect_low) else $error("collect active in readout"); // R20

  property p_next_loc;
    @(posedge clk_in) disable iff (!resetn_in)
    store && mode == gms_pkg::GMS_MSCAL && !end_pt && !stop_p |=> wptr == $past(wptr) + AW'(1);
  endproperty
  a_next_loc: assert property (p_next_loc) else $error("pointer did not advance"); // R3

  property p_evt_stop;
    @(posedge clk_in) disable iff (!resetn_in)
    end_pt && mode == gms_pkg::GMS_EVENT && evt_next >= points && !stop_p |=>
      st == gms_pkg::GMS_IDLE || st == gms_pkg::GMS_WREP;
  endproperty
  a_evt_stop: assert property (p_evt_stop) else $error("event run did not stop"); // R12

  property p_in_prog;
    @(posedge clk_in) disable iff (!resetn_in)
    st == gms_pkg::GMS_IDLE && start_p && !stop_p |=> in_prog && !armed_n_out;
  endproperty
  a_in_prog: assert property (p_in_prog) else $error("progress status not set"); // R16

  property p_rep_exp;
    @(posedge clk_in) disable iff (!resetn_in)
    rep_hit && busy |=> rep_exp;
  endproperty
  a_rep_exp: assert property (p_rep_exp) else $error("repeat expiry not flagged"); // R15

  property p_trig_st;
    @(posedge clk_in) disable iff (!resetn_in)
    st == gms_pkg::GMS_ARM && trig_hit && disable_arm_n_in && !stop_p |=> trig_st ##1 trig_st;
  endproperty
  a_trig_st: assert property (p_trig_st) else $error("triggered status not held"); // R17

  c_curve: cover property (@(posedge clk_in) end_pt && done && mode == gms_pkg::GMS_MSCAL);
  c_event: cover property (@(posedge clk_in) store && mode == gms_pkg::GMS_EVENT);
  c_repexp: cover property (@(posedge clk_in) rep_hit && busy);
  c_sweep: cover property (@(posedge clk_in) st == gms_pkg::GMS_WSWP ##1 st == gms_pkg::GMS_CNT);
endmodule // gms_top

// [include/gms_cnt_if.sv]
// Link between the sequencer and one channel counter
`timescale 1ns/10ps
interface gms_cnt_if #(parameter int CNT_W = 32);
  logic             clear;
  logic             enable;
  logic             neg_edge;
  logic [CNT_W-1:0] count;
  modport ctrl (output clear, output enable, output neg_edge, input count);
  modport cnt  (input clear, input enable, input neg_edge, output count);
endinterface

// [include/gms_params.svh]
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef GMS_PARAMS_SVH
`define GMS_PARAMS_SVH

// Clock and timing
`define GMS_CLK_PS        4000
`define GMS_READOUT_NS    50
`define GMS_MIN_TPP_NS    250
`define GMS_READOUT_CYC   ((`GMS_READOUT_NS * 1000 + `GMS_CLK_PS - 1) / `GMS_CLK_PS)
`define GMS_MIN_TPP_CYC   ((`GMS_MIN_TPP_NS * 1000 + `GMS_CLK_PS - 1) / `GMS_CLK_PS)

// Register byte offsets
`define GMS_OFS_CTRL      8'h00
`define GMS_OFS_TPP       8'h04
`define GMS_OFS_POINTS    8'h08
`define GMS_OFS_SWEEPS    8'h0C
`define GMS_OFS_REPEAT    8'h10
`define GMS_OFS_THRESH    8'h14
`define GMS_OFS_BASE      8'h18
`define GMS_OFS_STATUS    8'h1C
`define GMS_OFS_RDADDR    8'h20
`define GMS_OFS_RDCH0     8'h24
`define GMS_OFS_RDCH1     8'h28
`define GMS_OFS_RDTIME    8'h2C
`define GMS_OFS_EVTCNT    8'h30

// Control fields
`define GMS_CTRL_START    0
`define GMS_CTRL_STOP     1
`define GMS_CTRL_MODE     3:2
`define GMS_CTRL_TCOND    5:4
`define GMS_CTRL_ACC      6
`define GMS_CTRL_REP      7
`define GMS_CTRL_STEP     8
`define GMS_CTRL_NEG      10:9

// Status fields
`define GMS_ST_PROG       0
`define GMS_ST_TRIG       1
`define GMS_ST_REPEXP     2
`define GMS_ST_ARMED      3
`define GMS_ST_COLLECT    4

// Reset values and points limits
`define GMS_RST_TPP       32'h0000_003F
`define GMS_RST_POINTS    17'h0_0400
`define GMS_RST_SWEEPS    16'h0001
`define GMS_RST_REPEAT    32'h0000_0000
`define GMS_RST_THRESH    32'h0000_0000
`define GMS_POINTS_MIN    17'h0_0002
`define GMS_POINTS_MAX    17'h1_0000

`endif

// [include/gms_pkg.sv]
// Types shared by the sequencer modules
package gms_pkg;
  typedef enum logic [2:0] {
    GMS_IDLE = 3'b000,
    GMS_ARM  = 3'b001,
    GMS_CNT  = 3'b010,
    GMS_READ = 3'b011,
    GMS_WPT  = 3'b100,
    GMS_WSWP = 3'b101,
    GMS_WREP = 3'b110
  } gms_state_t;
  typedef enum logic [1:0] {
    GMS_RATES = 2'b00,
    GMS_MSCAL = 2'b01,
    GMS_EVENT = 2'b10
  } gms_mode_t;
  typedef enum logic [1:0] {
    GMS_TNONE = 2'b00,
    GMS_TRISE = 2'b01,
    GMS_TFALL = 2'b10
  } gms_tcond_t;
endpackage

// [sim/gms_pulse_src.sv]
// Detector pulse source answering each collection window
`timescale 1ns/10ps
module gms_pulse_src (
  // Clock and window
  input  wire logic       clk_in,
  input  wire logic       collect_n_in,
  input  wire logic [3:0] n0_in,
  // Detector lines
  output logic      [1:0] det_out
);
  logic       prev_n = 1'b1;
  logic [5:0] t      = 6'h00;
  // Pulses sit well inside the window so no edge lands in readout
  always @(posedge clk_in) begin
    prev_n <= collect_n_in;
    t <= (prev_n & ~collect_n_in) ? 6'h01 : ((t != 6'h00) ? t + 6'h01 : 6'h00);
    det_out[0] <= (t >= 6'h04) && (t < 6'h04 + 6'(2 * n0_in)) && !t[0];
    det_out[1] <= (t >= 6'h04) && (t < 6'h0A) && !t[0];
  end
endmodule // gms_pulse_src

// [sim/gms_top_tb_top.sv]
// Self-checking bench for the multiscaler sequencer
`timescale 1ns/10ps
module gms_top_tb_top;
  logic        clk_in    = 1'b0;
  logic        resetn_in = 1'b0;
  logic        psel      = 1'b0;
  logic        pen       = 1'b0;
  logic        pwr       = 1'b0;
  logic        trig      = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [3:0]  n0        = 4'h3;
  logic [31:0] prdata;
  logic        pready, pslverr, armed_n, measure_n, collect_n;
  logic [1:0]  det;
  logic [32:0] exp_q[$];
  int          miscompares = 0;
  int          comparisons = 0;
  int          n;
  // Free running clock
  always #2 clk_in = ~clk_in;
  gms_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .det_in(det), .trig_in(trig), .disable_arm_n_in(1'b1),
    .disable_collect_n_in(1'b1), .armed_n_out(armed_n), .measure_n_out(measure_n),
    .collect_n_out(collect_n));
  gms_pulse_src u_src (.clk_in(clk_in), .collect_n_in(collect_n), .n0_in(n0), .det_out(det));
  task automatic check(input string what, input logic [32:0] e, input logic [32:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One transfer; released only after pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    while (s !== v && c < lim) begin
      @(posedge clk_in);
      c++;
    end
    if (c >= lim) begin
      miscompares++;
      summarize();
    end
  endtask
  // Read results are matched against the oldest note
  always @(posedge clk_in) begin
    if (psel && pen && pready === 1'b1 && !pwr && exp_q.size() > 0) check("read", exp_q.pop_front(), {pslverr, prdata});
  end
  initial begin
    void'($urandom(32'h980C));
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(8'h04, 33'h3F);
    rd(8'h08, 33'h400);
    rd(8'h0C, 33'h1);
    rd(8'h40, 33'h1_0000_0000);
    apb(1'b1, 8'h08, 32'h0002_0000);
    rd(8'h08, 33'h1_0000);
    apb(1'b1, 8'h08, 32'h1);
    rd(8'h08, 33'h2);
    // Multiscaler, no trigger, two points
    n0 <= 4'($urandom_range(10, 3));
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h04, 32'h3F);
    apb(1'b1, 8'h00, 32'h5);
    wait_lvl(collect_n, 1'b0, 10, n);
    check("armed", 33'h0, {32'h0, armed_n});
    wait_lvl(collect_n, 1'b1, 60, n);
    check("window", 33'd50, 33'(n));
    wait_lvl(collect_n, 1'b0, 20, n);
    check("readout", 33'd13, 33'(n));
    wait_lvl(measure_n, 1'b1, 100, n);
    apb(1'b1, 8'h20, 32'h1);
    rd(8'h24, {29'h0, n0});
    rd(8'h28, 33'h3);
    // Rising edge start: armed but idle until the edge
    apb(1'b1, 8'h00, 32'h15);
    repeat (20) @(posedge clk_in);
    check("armwait", 33'h1, {31'h0, armed_n, collect_n});
    trig <= 1'b1;
    wait_lvl(collect_n, 1'b0, 5, n);
    wait_lvl(measure_n, 1'b1, 200, n);
    trig <= 1'b0;
    // Event mode, every interval over threshold
    apb(1'b1, 8'h14, 32'h2);
    apb(1'b1, 8'h00, 32'h9);
    wait_lvl(collect_n, 1'b0, 10, n);
    wait_lvl(measure_n, 1'b1, 300, n);
    rd(8'h30, 33'h2);
    apb(1'b1, 8'h20, 32'h1);
    rd(8'h24, {29'h0, n0});
    rd(8'h28, 33'h3);
    rd(8'h2C, 33'h71);
    // Two sweeps, falling count edge, one trigger before each point
    apb(1'b1, 8'h0C, 32'h2);
    apb(1'b1, 8'h00, 32'h755);
    for (int i = 0; i < 4; i++) begin
      repeat (20) @(posedge clk_in);
      check("stepwait", 33'h1, {32'h0, collect_n});
      trig <= 1'b1;
      wait_lvl(collect_n, 1'b0, 5, n);
      trig <= 1'b0;
      wait_lvl(collect_n, 1'b1, 60, n);
    end
    wait_lvl(measure_n, 1'b1, 20, n);
    // Earlier event result plus two sweeps
    rd(8'h24, 33'(3 * n0));
    rd(8'h28, 33'h9);
    // Rates mode repeating faster than one interval lasts
    apb(1'b1, 8'h10, 32'h14);
    apb(1'b1, 8'h00, 32'h81);
    wait_lvl(collect_n, 1'b0, 10, n);
    wait_lvl(collect_n, 1'b1, 60, n);
    wait_lvl(collect_n, 1'b0, 20, n);
    apb(1'b1, 8'h00, 32'h2);
    rd(8'h1C, 33'h6);
    apb(1'b1, 8'h1C, 32'h4);
    rd(8'h1C, 33'h2);
    summarize();
  end
endmodule // gms_top_tb_top
